// ==== logic/dpc_top.v ====
// Purpose: double data rate pin cell with an AXI4-Lite control slave
// Assumes: clock_i 10 MHz, rstn_i asynchronous active low, inputs synchronous
// Notes:   pin_o follows the clock phase in push-pull, pin_oe_n_o in open drain, so they are not plain flops
//          control writes need byte lane 0; unmapped offsets answer SLVERR
//          status is live: a read shows the cell state at the take edge
//          changing init_high with hold low has no effect until hold is set again
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "dpc_map.vh"

module dpc_top
(
    input  wire                   clock_i,
    input  wire                   rstn_i,
    // AXI4-Lite write address
    input  wire                   s_axi_awvalid_i,
    output reg                    s_axi_awready_o,
    input  wire [`DPC_ADDR_W-1:0] s_axi_awaddr_i,
    // AXI4-Lite write data
    input  wire                   s_axi_wvalid_i,
    output reg                    s_axi_wready_o,
    input  wire [31:0]            s_axi_wdata_i,
    input  wire [3:0]             s_axi_wstrb_i,
    // AXI4-Lite write response
    output reg                    s_axi_bvalid_o,
    input  wire                   s_axi_bready_i,
    output reg  [1:0]             s_axi_bresp_o,
    // AXI4-Lite read address
    input  wire                   s_axi_arvalid_i,
    output reg                    s_axi_arready_o,
    input  wire [`DPC_ADDR_W-1:0] s_axi_araddr_i,
    // AXI4-Lite read data
    output reg                    s_axi_rvalid_o,
    input  wire                   s_axi_rready_i,
    output reg  [31:0]            s_axi_rdata_o,
    output reg  [1:0]             s_axi_rresp_o,
    // core side data
    input  wire                   tx_rise_i,
    input  wire                   tx_fall_i,
    input  wire                   tx_en_i,
    output reg                    rx_rise_o,
    output reg                    rx_fall_o,
    // pin
    input  wire                   pin_i,
    output wire                   pin_o,
    output wire                   pin_oe_n_o
);

    // control register
    reg                    hold;
    reg                    init_high;
    reg  [1:0]             mode;
    reg                    open_drain;

    // write channel state
    reg                    aw_held;
    reg                    w_held;
    reg  [`DPC_ADDR_W-1:0] aw_addr;
    reg  [31:0]            w_data;
    reg  [3:0]             w_strb;

    // cell outputs
    wire                   cell_rx_rise;
    wire                   cell_rx_fall;
    wire                   cell_oe;

    // readback words and handshake events
    reg  [31:0]            status_word;
    reg  [31:0]            ctrl_word;
    wire                   do_write;
    wire                   aw_take;
    wire                   w_take;
    wire                   ar_take;
    wire                   b_done;
    wire                   r_done;
    wire                   wr_ctrl;

    // one address decode shared by the read and write paths
    function is_mapped;
        input [`DPC_ADDR_W-1:0] addr;
        begin
            is_mapped = (addr == `DPC_OFS_CTRL) || (addr == `DPC_OFS_STATUS);
        end
    endfunction

    // control register select, shared by the write commit and the read mux
    function is_ctrl;
        input [`DPC_ADDR_W-1:0] addr;
        begin
            is_ctrl = (addr == `DPC_OFS_CTRL);
        end
    endfunction

    // unmapped offsets answer SLVERR on both paths and change nothing
    function [1:0] resp_of;
        input [`DPC_ADDR_W-1:0] addr;
        begin
            resp_of = is_mapped(addr) ? `DPC_RESP_OKAY : `DPC_RESP_SLVERR;
        end
    endfunction

    // read mux; unmapped offsets read as zero
    function [31:0] read_word;
        input [`DPC_ADDR_W-1:0] addr;
        input [31:0]            ctrl_val;
        input [31:0]            stat_val;
        begin
            if (is_ctrl(addr))
                read_word = ctrl_val;
            else if (addr == `DPC_OFS_STATUS)
                read_word = stat_val;
            else
                read_word = `DPC_DATA_ZERO;
        end
    endfunction

    // handshake events, one name each so the processes read plainly
    assign aw_take  = s_axi_awready_o & s_axi_awvalid_i;
    assign w_take   = s_axi_wready_o & s_axi_wvalid_i;
    assign ar_take  = s_axi_arready_o & s_axi_arvalid_i;
    assign b_done   = s_axi_bvalid_o & s_axi_bready_i;
    assign r_done   = s_axi_rvalid_o & s_axi_rready_i;

    // the write commits once both halves are in and no answer is pending
    assign do_write = aw_held & w_held & ~s_axi_bvalid_o;
    // a control write needs its offset and byte lane 0; other lanes are empty
    assign wr_ctrl  = do_write & is_ctrl(aw_addr) & w_strb[0];

    // control readback built field by field, unused bits read as zero
    always @*
    begin
        ctrl_word                                      = `DPC_DATA_ZERO;
        ctrl_word[`DPC_CTRL_HOLD]                      = hold;
        ctrl_word[`DPC_CTRL_INIT_HIGH]                 = init_high;
        ctrl_word[`DPC_CTRL_MODE_HI:`DPC_CTRL_MODE_LO] = mode;
        ctrl_word[`DPC_CTRL_OPEN_DRAIN]                = open_drain;
    end

    // status is live cell state plus the level of the shared control
    always @*
    begin
        status_word                    = `DPC_DATA_ZERO;
        status_word[`DPC_STAT_RX_RISE] = cell_rx_rise;
        status_word[`DPC_STAT_RX_FALL] = cell_rx_fall;
        status_word[`DPC_STAT_OE]      = cell_oe;
        status_word[`DPC_STAT_ACLR]    = hold;
    end

    // write address channel: taken alone, held until the write commits
    // awready reopens only once the response has gone, so one write at a time
    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_axi_awready_o <= 1'b0;
            aw_held         <= 1'b0;
            aw_addr         <= {`DPC_ADDR_W{1'b0}};
        end
        else if (aw_take)
        begin
            s_axi_awready_o <= 1'b0;
            aw_held         <= 1'b1;
            aw_addr         <= s_axi_awaddr_i;
        end
        else if (do_write)
            aw_held <= 1'b0;
        else if (!aw_held && !s_axi_bvalid_o)
            s_axi_awready_o <= 1'b1;
    end

    // write data channel, independent of the address so either may come first
    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_axi_wready_o <= 1'b0;
            w_held         <= 1'b0;
            w_data         <= `DPC_DATA_ZERO;
            w_strb         <= 4'h0;
        end
        else if (w_take)
        begin
            s_axi_wready_o <= 1'b0;
            w_held         <= 1'b1;
            w_data         <= s_axi_wdata_i;
            w_strb         <= s_axi_wstrb_i;
        end
        else if (do_write)
            w_held <= 1'b0;
        else if (!w_held && !s_axi_bvalid_o)
            s_axi_wready_o <= 1'b1;
    end

    // write response; unmapped offsets answer SLVERR and change nothing
    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `DPC_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= resp_of(aw_addr);
        end
        else if (b_done)
            s_axi_bvalid_o <= 1'b0;
    end

    // control register; all fields live in byte lane 0
    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            hold       <= `DPC_RST_HOLD;
            init_high  <= `DPC_RST_INIT_HIGH;
            mode       <= `DPC_RST_MODE;
            open_drain <= `DPC_RST_OPEN_DRAIN;
        end
        else if (wr_ctrl)
        begin
            hold       <= w_data[`DPC_CTRL_HOLD];
            init_high  <= w_data[`DPC_CTRL_INIT_HIGH];
            mode       <= w_data[`DPC_CTRL_MODE_HI:`DPC_CTRL_MODE_LO];
            open_drain <= w_data[`DPC_CTRL_OPEN_DRAIN];
        end
    end

    // read channel: answer one cycle after the address is taken
    // arready stays low while an answer waits, so one read at most is open
    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= `DPC_DATA_ZERO;
            s_axi_rresp_o   <= `DPC_RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rresp_o   <= resp_of(s_axi_araddr_i);
            s_axi_rdata_o   <= read_word(s_axi_araddr_i, ctrl_word, status_word);
        end
        else if (r_done)
            s_axi_rvalid_o <= 1'b0;
        else if (!s_axi_rvalid_o)
            s_axi_arready_o <= 1'b1;
    end

    // hold drives the one shared control; releasing it ends configuration
    // init_high picks clear or preset, so one source serves either start level
    dpc_cell u_cell
    (
        .clock_i      (clock_i),
        .aclr_i       (hold),
        .init_high_i  (init_high),
        .mode_i       (mode),
        .open_drain_i (open_drain),
        .tx_rise_i    (tx_rise_i),
        .tx_fall_i    (tx_fall_i),
        .tx_en_i      (tx_en_i),
        .pin_i        (pin_i),
        .pin_o        (pin_o),
        .pin_oe_n_o   (pin_oe_n_o),
        .rx_rise_o    (cell_rx_rise),
        .rx_fall_o    (cell_rx_fall),
        .oe_o         (cell_oe)
    );

    // core-side copies so the top outputs come from flops; costs one cycle
    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rx_rise_o <= 1'b0;
            rx_fall_o <= 1'b0;
        end
        else
        begin
            rx_rise_o <= cell_rx_rise;
            rx_fall_o <= cell_rx_fall;
        end
    end

endmodule

`default_nettype wire

// ==== logic/dpc_map.vh ====
// Purpose: constants for the double data rate pin cell and its register slave
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   all offsets are byte addresses
`ifndef DPC_MAP_VH
`define DPC_MAP_VH

// register byte offsets
`define DPC_ADDR_W          4
`define DPC_OFS_CTRL        4'h0
`define DPC_OFS_STATUS      4'h4

// control register fields
`define DPC_CTRL_HOLD       0
`define DPC_CTRL_INIT_HIGH  1
`define DPC_CTRL_MODE_LO    2
`define DPC_CTRL_MODE_HI    3
`define DPC_CTRL_OPEN_DRAIN 4

// control register reset values
`define DPC_RST_HOLD        1'b1
`define DPC_RST_INIT_HIGH   1'b0
`define DPC_RST_MODE        2'h0
`define DPC_RST_OPEN_DRAIN  1'b0

// status register fields
`define DPC_STAT_RX_RISE    0
`define DPC_STAT_RX_FALL    1
`define DPC_STAT_OE         2
`define DPC_STAT_ACLR       3

// transfer modes
`define DPC_MODE_IN         2'h0
`define DPC_MODE_OUT        2'h1
`define DPC_MODE_BIDIR      2'h2

// bus answers
`define DPC_RESP_OKAY       2'h0
`define DPC_RESP_SLVERR     2'h2
`define DPC_DATA_ZERO       32'h0000_0000

`endif

// ==== logic/dpc_cell.v ====
// Purpose: six-register double data rate pin cell
// Assumes: one clock; falling-edge registers use the same clock inverted
// Notes:   one common asynchronous control clears or presets every register
`timescale 1ns/1ns
`default_nettype none
`include "dpc_map.vh"

module dpc_cell
(
    input  wire       clock_i,
    input  wire       aclr_i,
    input  wire       init_high_i,
    input  wire [1:0] mode_i,
    input  wire       open_drain_i,
    input  wire       tx_rise_i,
    input  wire       tx_fall_i,
    input  wire       tx_en_i,
    input  wire       pin_i,
    output wire       pin_o,
    output wire       pin_oe_n_o,
    output wire       rx_rise_o,
    output wire       rx_fall_o,
    output wire       oe_o
);

    wire       clr_n;
    wire       pre_n;
    wire       in_en;
    wire       out_en;
    wire       drive_val;
    reg        in_rise;
    reg        in_fall;
    reg        in_fall_al;
    reg        out_rise;
    reg        out_fall;
    reg        oe_fall;

    // one shared source: low start means clear only, high start means preset only
    assign clr_n = ~(aclr_i & ~init_high_i);
    assign pre_n = ~(aclr_i &  init_high_i);

    // mode decode; the bidirectional mode is both paths running together
    assign in_en  = (mode_i == `DPC_MODE_IN)  || (mode_i == `DPC_MODE_BIDIR);
    assign out_en = (mode_i == `DPC_MODE_OUT) || (mode_i == `DPC_MODE_BIDIR);

    // rising-edge input sample
    always @(posedge clock_i or negedge clr_n or negedge pre_n)
    begin
        if (!clr_n)
            in_rise <= 1'b0;
        else if (!pre_n)
            in_rise <= 1'b1;
        else if (in_en)
            in_rise <= pin_i;
    end

    // falling-edge input sample
    always @(negedge clock_i or negedge clr_n or negedge pre_n)
    begin
        if (!clr_n)
            in_fall <= 1'b0;
        else if (!pre_n)
            in_fall <= 1'b1;
        else if (in_en)
            in_fall <= pin_i;
    end

    // realign the falling sample so both bits leave on the rising edge
    always @(posedge clock_i or negedge clr_n or negedge pre_n)
    begin
        if (!clr_n)
            in_fall_al <= 1'b0;
        else if (!pre_n)
            in_fall_al <= 1'b1;
        else if (in_en)
            in_fall_al <= in_fall;
    end

    // rising-edge output launch, new bit every cycle with no idle slot
    always @(posedge clock_i or negedge clr_n or negedge pre_n)
    begin
        if (!clr_n)
            out_rise <= 1'b0;
        else if (!pre_n)
            out_rise <= 1'b1;
        else if (out_en)
            out_rise <= tx_rise_i;
    end

    // falling-edge output launch; tx_fall_i must hold until the falling edge
    always @(negedge clock_i or negedge clr_n or negedge pre_n)
    begin
        if (!clr_n)
            out_fall <= 1'b0;
        else if (!pre_n)
            out_fall <= 1'b1;
        else if (out_en)
            out_fall <= tx_fall_i;
    end

    // enable waits for the falling edge so the far side can turn the bus round
    always @(negedge clock_i or negedge clr_n or negedge pre_n)
    begin
        if (!clr_n)
            oe_fall <= 1'b0;
        else if (!pre_n)
            oe_fall <= 1'b1;
        else
            oe_fall <= tx_en_i & out_en;
    end

    // high phase shows the rising register, low phase the falling one
    assign drive_val  = clock_i ? out_rise : out_fall;
    // open drain never drives a one: it pulls low or lets go
    assign pin_o      = open_drain_i ? 1'b0 : drive_val;
    assign pin_oe_n_o = ~(oe_fall & ~(open_drain_i & drive_val));
    assign rx_rise_o  = in_rise;
    assign rx_fall_o  = in_fall_al;
    assign oe_o       = oe_fall;

endmodule

`default_nettype wire

// ==== tb/dpc_chk_asserts.sv ====
// Purpose: bus handshake and pin phase checks for dpc_top
// Assumes: only the top ports are visible
// Notes:   pin checks only look while the cell drives the pin
`timescale 1ns/1ns
`default_nettype none

module dpc_chk
(
    input wire logic        clock_i,
    input wire logic        rstn_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic        tx_rise_i,
    input wire logic        tx_fall_i,
    input wire logic        tx_en_i,
    input wire logic        pin_o,
    input wire logic        pin_oe_n_o
);
    logic rise_cap;
    logic fall_cap;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);

    // copies of what each edge should have launched
    always @(posedge clock_i) rise_cap <= tx_rise_i;
    always @(negedge clock_i) fall_cap <= tx_fall_i;

    property p_aw_take;
        s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o;
    endproperty
    a_aw_take: assert property (p_aw_take) else $error("aw ready stayed high after take");
    property p_b_hold;
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_b_done;
        s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o ##1 (s_axi_awready_o && s_axi_wready_o);
    endproperty
    a_b_done: assert property (p_b_done) else $error("write channel not reopened");
    property p_r_take;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
    endproperty
    a_r_take: assert property (p_r_take) else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data changed while waiting");
    property p_r_done;
        s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o ##1 s_axi_arready_o;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read channel not reopened");
    property p_oe_src;
        !pin_oe_n_o |-> tx_en_i;
    endproperty
    a_oe_src: assert property (p_oe_src) else $error("pin driven without enable");
    property p_hi_phase;
        @(negedge clock_i) !pin_oe_n_o |-> pin_o == rise_cap;
    endproperty
    a_hi_phase: assert property (p_hi_phase) else $error("high phase shows wrong bit");
    property p_lo_phase;
        !pin_oe_n_o |-> pin_o == fall_cap;
    endproperty
    a_lo_phase: assert property (p_lo_phase) else $error("low phase shows wrong bit");
endmodule

bind dpc_top dpc_chk i_dpc_chk (.*);

`default_nettype wire

// ==== tb/dpc_mem_model.sv ====
// Purpose: far-side memory device on the pin
// Assumes: pin has a pull-up; device launches 10 ns after each edge
// Notes:   the delay keeps the design's sampling edge clear of pin changes
`timescale 1ns/1ns
`default_nettype none

module dpc_mem_model
(
    input  wire logic clock_i,
    input  wire logic pin_o,
    input  wire logic pin_oe_n_o,
    input  wire logic dev_en_i,
    input  wire logic dev_hi_i,
    input  wire logic dev_lo_i,
    output wire logic pin_i
);
    logic dev_q = 1'b1;

    // high phase carries dev_hi, low phase dev_lo
    always @(clock_i) dev_q <= #10 (clock_i ? dev_hi_i : dev_lo_i);

    // cell wins when it drives, else device, else pull-up
    assign pin_i = !pin_oe_n_o ? pin_o : (dev_en_i ? dev_q : 1'b1);
endmodule

`default_nettype wire

// ==== tb/tb_dpc_top.sv ====
// Purpose: register, input and output tests of dpc_top
// Assumes: 10 MHz clock, AXI4-Lite master tasks
// Notes:   pin values are looked at a quarter cycle into each phase
`timescale 1ns/1ns
`default_nettype none
`include "dpc_map.vh"

module tb_dpc_top;
    logic        clock_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic [3:0]  s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0, s_axi_wstrb_i = 4'h0;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    logic        tx_rise_i = 1'b1, tx_fall_i = 1'b1, tx_en_i = 1'b1;
    logic        rx_rise_o, rx_fall_o, pin_i, pin_o, pin_oe_n_o;
    logic        dev_en_i = 1'b0, dev_hi_i = 1'b0, dev_lo_i = 1'b0;
    int          err_total = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          k;
    localparam logic [4:0] PR = 5'h0d;
    localparam logic [4:0] PF = 5'h06;

    dpc_top       i_dpc_top (.*);
    dpc_mem_model i_dpc_mem_model (.*);

    always #50 clock_i = ~clock_i;

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // both write halves offered together, each dropped once taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        bit aw;
        bit w;
        aw = 0;
        w = 0;
        @(posedge clock_i);
        s_axi_awvalid_i <= 1'b1;
        s_axi_awaddr_i <= a;
        s_axi_wvalid_i <= 1'b1;
        s_axi_wdata_i <= d;
        s_axi_wstrb_i <= s;
        while (!(aw && w))
        begin
            @(posedge clock_i);
            if (!aw && s_axi_awready_o === 1'b1)
            begin
                aw = 1;
                s_axi_awvalid_i <= 1'b0;
            end
            if (!w && s_axi_wready_o === 1'b1)
            begin
                w = 1;
                s_axi_wvalid_i <= 1'b0;
            end
        end
        // ready only once the answer stands, so the slave must hold it a cycle
        do @(posedge clock_i); while (s_axi_bvalid_o !== 1'b1);
        s_axi_bready_i <= 1'b1;
        do @(posedge clock_i); while (s_axi_bvalid_o !== 1'b1);
        s_axi_bready_i <= 1'b0;
        check(32'(s_axi_bresp_o), 32'(er));
    endtask

    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clock_i);
        s_axi_arvalid_i <= 1'b1;
        s_axi_araddr_i <= a;
        do @(posedge clock_i); while (s_axi_arready_o !== 1'b1);
        s_axi_arvalid_i <= 1'b0;
        // late ready makes the slave hold rdata and rresp for a cycle
        do @(posedge clock_i); while (s_axi_rvalid_o !== 1'b1);
        s_axi_rready_i <= 1'b1;
        do @(posedge clock_i); while (s_axi_rvalid_o !== 1'b1);
        s_axi_rready_i <= 1'b0;
        check(s_axi_rdata_o, ed);
        check(32'(s_axi_rresp_o), 32'(er));
    endtask

    // open drain never drives high, the pull-up makes the one
    task automatic chk_pin(input bit od, input logic v);
        check(32'({pin_o, pin_oe_n_o, pin_i}), od ? 32'({1'b0, v, v}) : 32'({v, 1'b0, v}));
    endtask

    // new bit pair every cycle, no idle between
    task automatic run_out(input bit od);
        axi_wr(`DPC_OFS_CTRL, od ? 32'h14 : 32'h04, 4'hf, `DPC_RESP_OKAY);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clock_i);
            tx_rise_i <= PR[i];
            tx_fall_i <= PF[i];
            #25;
            if (i > 0) chk_pin(od, PR[i-1]);
            @(negedge clock_i);
            #25;
            chk_pin(od, PF[i]);
        end
    endtask

    // hang guard, the sequence needs well under a thousand cycles
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            $display("BAD %0t timeout after %0d cycles", $time, cyc);
            give_verdict();
        end
    end

    initial
    begin
        repeat (4) @(posedge clock_i);
        rstn_i <= 1'b1;
        axi_rd(`DPC_OFS_CTRL, 32'h1, `DPC_RESP_OKAY);
        axi_rd(`DPC_OFS_STATUS, 32'h8, `DPC_RESP_OKAY);
        axi_rd(4'h8, `DPC_DATA_ZERO, `DPC_RESP_SLVERR);
        axi_wr(4'hc, 32'h0, 4'hf, `DPC_RESP_SLVERR);
        axi_wr(`DPC_OFS_CTRL, 32'h0, 4'h0, `DPC_RESP_OKAY);
        axi_wr(`DPC_OFS_STATUS, 32'h0, 4'hf, `DPC_RESP_OKAY);
        axi_rd(`DPC_OFS_CTRL, 32'h1, `DPC_RESP_OKAY);
        axi_wr(`DPC_OFS_CTRL, 32'h3, 4'hf, `DPC_RESP_OKAY);
        axi_rd(`DPC_OFS_STATUS, 32'hf, `DPC_RESP_OKAY);
        axi_wr(`DPC_OFS_CTRL, 32'h1, 4'hf, `DPC_RESP_OKAY);
        axi_rd(`DPC_OFS_STATUS, 32'h8, `DPC_RESP_OKAY);
        tx_en_i <= 1'b0;
        dev_en_i <= 1'b1;
        // bidirectional first, then input only
        for (int m = 0; m < 2; m++)
        begin
            axi_wr(`DPC_OFS_CTRL, m ? 32'h0 : 32'h8, 4'hf, `DPC_RESP_OKAY);
            for (k = 0; k < 4; k++)
            begin
                dev_hi_i <= k[0];
                dev_lo_i <= k[1];
                repeat (4) @(posedge clock_i);
                check(32'({rx_rise_o, rx_fall_o}), 32'({k[1], k[0]}));
            end
        end
        dev_en_i <= 1'b0;
        tx_en_i <= 1'b1;
        run_out(1'b0);
        run_out(1'b1);
        // turnaround: enable waits for the falling edge
        axi_wr(`DPC_OFS_CTRL, 32'h8, 4'hf, `DPC_RESP_OKAY);
        tx_en_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        tx_en_i <= 1'b1;
        #25;
        check(32'(pin_oe_n_o), 32'h1);
        @(negedge clock_i);
        #25;
        check(32'(pin_oe_n_o), 32'h0);
        give_verdict();
    end
endmodule

`default_nettype wire
